// *** src/spiph_core.sv ***
// Serial peripheral block: phase formats, start latency, overrun and mode fault
// Functional notes
// - Phase 1 master drives first bit at first edge
// - Phase 1 slave starts on first clock edge
// - Phase 1 select may stay low between bytes
// - Slave drives data out only while selected
// - Master transfer starts only on data write
// - Phase 0 idle half bit, phase 1 edge first
// - Master clock divider runs only enabled master
// - Clock edges at bus clock low midpoint
// - Start delay at most one bit time
// - Overrun on first capture, keep old byte
// - Overrun and fault share one error enable
// - Fault flag set only with fault enable
// - Receive and error requests share one output
// - Master sets fault when select sampled low
// - Master fault: disable, empty, clear, release pins
// - Fault leaves master select bit unchanged
// - Slave faults when select rises mid transfer
// - Phase 0 select pulse faults, phase 1 not
// - Slave fault keeps enable and slave logic
// - Deselected slave floats output, ignores clocks
// - Fault clears by status read, control write
// - Receive full set on move, read clears
// - Phase 0 select fall starts each transfer
// - Disabled block partially resets, sets transmit empty, keeps other flags
`timescale 1ns/1ps
`include "spiph_defines.svh"

module spiph_core (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Serial clock pin
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  // Master out slave in pin
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_o,
  // Master in slave out pin
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // Slave select, active low
  input  wire logic        ss_n_i,
  // Interrupt requests
  output logic             irq_rx_err_o,
  output logic             irq_tx_o
);

  // ==========================================================
  // Input synchronisers
  logic ss_m, ss_s, ss_d, sck_m, sck_s, sck_d, mosi_m, mosi_s, miso_m, miso_s;

  // Pins are asynchronous; third stage only feeds edge detect
  // Two-flop delay on miso: master capture needs rate /8 or slower
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {ss_m, ss_s, ss_d}    <= 3'h7;
      {sck_m, sck_s, sck_d} <= 3'h0;
      {mosi_m, mosi_s}      <= 2'h0;
      {miso_m, miso_s}      <= 2'h0;
    end else begin
      {ss_m, ss_s, ss_d}    <= {ss_n_i, ss_m, ss_s};
      {sck_m, sck_s, sck_d} <= {sck_i, sck_m, sck_s};
      {mosi_m, mosi_s}      <= {mosi_i, mosi_m};
      {miso_m, miso_s}      <= {miso_i, miso_m};
    end
  end

  // ==========================================================
  // Bus handshake
  logic        wait_q, next_wait;
  logic [31:0] rdata_q, next_rdata;
  logic        acc;
  logic [5:0]  idx;
  logic [7:0]  ctl_val, stat_val;

  // Control
  logic en_q, mst_q, clock_polarity_select_q, clock_phase_select_q, rxie_q, txie_q, erie_q, mode_fault_enable_q;
  logic [1:0] rate_q;
  // Flags and their clear sequences
  logic rxf_q, ovr_q, mode_fault_flag_q, txe_q, rxf_arm_q, ovr_arm_q, mode_fault_flag_arm_q;
  // Data path
  spiph_pkg::spiph_byte_t txbuf_q, rxdata_q, tx_sh_q, rx_sh_q;
  spiph_pkg::spiph_state_e st_q;
  logic [3:0] ecnt_q;
  logic [6:0] div_q;
  logic dout_q, drop_q, sck_q, sck_oe_q, mosi_oe_q, miso_oe_q, irq_re_q, irq_tx_q;

  assign idx      = avs_address_i[7:2];
  assign acc      = (avs_read_i | avs_write_i) & ~wait_q;
  assign ctl_val  = {rxie_q, 1'b0, mst_q, clock_polarity_select_q, clock_phase_select_q, 1'b0, en_q, txie_q};
  assign stat_val = {rxf_q, erie_q, ovr_q, mode_fault_flag_q, txe_q, mode_fault_enable_q, rate_q};

  // One wait cycle per access; data is latched while waiting
  always_comb begin
    next_wait  = ~((avs_read_i | avs_write_i) & wait_q);
    next_rdata = rdata_q;
    if (avs_read_i && wait_q) begin
      unique case (idx)
        `SPIPH_IDX_CTRL: next_rdata = {24'h000000, ctl_val};
        `SPIPH_IDX_STAT: next_rdata = {24'h000000, stat_val};
        `SPIPH_IDX_DATA: next_rdata = {24'h000000, rxdata_q};
        default:         next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= next_wait;
      rdata_q <= next_rdata;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  // ==========================================================
  // Core: registers, flags, divider and shift engine
  logic next_en, next_mst, next_clock_polarity_select, next_clock_phase_select, next_rxie, next_txie, next_erie, next_mode_fault_enable;
  logic [1:0] next_rate;
  logic next_rxf, next_ovr, next_mode_fault_flag, next_txe, next_rxf_arm, next_ovr_arm, next_mode_fault_flag_arm;
  spiph_pkg::spiph_byte_t next_txbuf, next_rxdata, next_tx_sh, next_rx_sh;
  spiph_pkg::spiph_state_e next_st;
  logic [3:0] next_ecnt;
  logic [6:0] next_div, hmask, fmask;
  logic next_dout, next_drop, next_sck, next_sck_oe, next_mosi_oe, next_miso_oe;
  logic next_irq_re, next_irq_tx;
  logic wr_ctl, wr_stat, wr_data, rd_stat, rd_data;
  logic m_act, s_act, half_tick, full_tick, start, edge_ev, lead, sample, fault_m, fault_s;
  spiph_pkg::spiph_byte_t src;

  assign wr_ctl  = acc & avs_write_i & avs_byteenable_i[0] & (idx == `SPIPH_IDX_CTRL);
  assign wr_stat = acc & avs_write_i & avs_byteenable_i[0] & (idx == `SPIPH_IDX_STAT);
  assign wr_data = acc & avs_write_i & avs_byteenable_i[0] & (idx == `SPIPH_IDX_DATA);
  assign rd_stat = acc & avs_read_i & (idx == `SPIPH_IDX_STAT);
  assign rd_data = acc & avs_read_i & (idx == `SPIPH_IDX_DATA);
  assign m_act   = en_q & mst_q;
  assign s_act   = en_q & ~mst_q;
  assign fault_m = m_act & mode_fault_enable_q & ~ss_s;
  assign fault_s = s_act & mode_fault_enable_q & (st_q == spiph_pkg::spiph_run) & ~ss_d & ss_s;

  always_comb begin
    unique case (rate_q)
      2'h0: begin hmask = `SPIPH_HALF_RATE_DIVIDE_TWO;   fmask = `SPIPH_FULL_RATE_DIVIDE_TWO;   end
      2'h1: begin hmask = `SPIPH_HALF_RATE_DIVIDE_EIGHT;   fmask = `SPIPH_FULL_RATE_DIVIDE_EIGHT;   end
      2'h2: begin hmask = `SPIPH_HALF_RATE_DIVIDE_THIRTYTWO;  fmask = `SPIPH_FULL_RATE_DIVIDE_THIRTYTWO;  end
      2'h3: begin hmask = `SPIPH_HALF_RATE_DIVIDE_ONETWENTYEIGHT; fmask = `SPIPH_FULL_RATE_DIVIDE_ONETWENTYEIGHT; end
    endcase
  end

  // edges launch from the bus clock, mid low phase outside
  assign half_tick = m_act & ((div_q & hmask) == hmask);
  assign full_tick = m_act & ((div_q & fmask) == fmask);

  // Next state of the whole core; later assignments win
  always_comb begin
    next_en = en_q;     next_mst = mst_q;   next_clock_polarity_select = clock_polarity_select_q;   next_clock_phase_select = clock_phase_select_q;
    next_rxie = rxie_q; next_txie = txie_q; next_erie = erie_q;   next_mode_fault_enable = mode_fault_enable_q;
    next_rate = rate_q; next_rxf = rxf_q;   next_ovr = ovr_q;     next_mode_fault_flag = mode_fault_flag_q;
    next_txe = txe_q;   next_txbuf = txbuf_q; next_rxdata = rxdata_q;
    next_rxf_arm = rxf_arm_q; next_ovr_arm = ovr_arm_q; next_mode_fault_flag_arm = mode_fault_flag_arm_q;
    next_tx_sh = tx_sh_q; next_rx_sh = rx_sh_q; next_st = st_q; next_ecnt = ecnt_q;
    next_dout = dout_q; next_drop = drop_q; next_sck = sck_q;
    start = 1'b0; edge_ev = 1'b0; lead = 1'b0; src = tx_sh_q;
    // divider free runs only as enabled master
    next_div = m_act ? 7'(div_q + 7'h01) : 7'h00;
    // Software writes
    if (wr_ctl) begin
      next_rxie = avs_writedata_i[`SPIPH_CTRL_RXIE];
      next_mst  = avs_writedata_i[`SPIPH_CTRL_MST];
      next_clock_polarity_select = avs_writedata_i[`SPIPH_CTRL_CLOCK_POLARITY_SELECT];
      next_clock_phase_select = avs_writedata_i[`SPIPH_CTRL_CLOCK_PHASE_SELECT];
      next_en   = avs_writedata_i[`SPIPH_CTRL_EN];
      next_txie = avs_writedata_i[`SPIPH_CTRL_TXIE];
    end
    if (wr_stat) begin
      next_erie   = avs_writedata_i[`SPIPH_STAT_ERIE];
      next_mode_fault_enable = avs_writedata_i[`SPIPH_STAT_MODE_FAULT_ENABLE];
      next_rate   = avs_writedata_i[`SPIPH_STAT_RATE];
    end
    // the data write queues the byte that starts a master transfer
    if (wr_data) begin
      next_txbuf = avs_writedata_i[7:0];
      next_txe   = 1'b0;
    end
    // Arm two-step clears with what the status read showed
    if (rd_stat) begin
      next_rxf_arm  = rdata_q[`SPIPH_STAT_RXF];
      next_ovr_arm  = rdata_q[`SPIPH_STAT_OVR];
      next_mode_fault_flag_arm = rdata_q[`SPIPH_STAT_MODE_FAULT_FLAG];
    end
    // status read then data read clears receive full
    if (rd_data && rxf_arm_q) begin
      next_rxf     = 1'b0;
      next_rxf_arm = 1'b0;
    end
    // overrun clears by the same sequence
    if (rd_data && ovr_arm_q) begin
      next_ovr     = 1'b0;
      next_ovr_arm = 1'b0;
    end
    // control write completes the clear only without a live fault
    if (wr_ctl && mode_fault_flag_arm_q && !fault_m && !fault_s) begin
      next_mode_fault_flag     = 1'b0;
      next_mode_fault_flag_arm = 1'b0;
    end
    if (fault_m || fault_s) begin
      next_mode_fault_flag_arm = 1'b0;
    end
    // Start and edge detection per role
    if (m_act) begin
      // start on a bit boundary, at most one bit time after write
      if (st_q == spiph_pkg::spiph_idle && !txe_q && full_tick) begin
        start = 1'b1;
      end
      // phase 1 start cycle is itself the first clock edge
      // phase 0 waits a half bit before the first edge
      edge_ev = (st_q == spiph_pkg::spiph_run && half_tick) || (start && clock_phase_select_q);
      lead    = (sck_q == clock_polarity_select_q);
    end else if (s_act && !ss_s) begin
      // clock edges count only while selected
      lead = (sck_s != clock_polarity_select_q);
      // phase 0 transfer starts at the select fall
      // select alone starts phase 0 only
      if (st_q == spiph_pkg::spiph_idle && !clock_phase_select_q && ss_d) begin
        start = 1'b1;
      end
      // phase 1 transfer starts at the first clock edge
      // select may have stayed low since the last byte
      if (st_q == spiph_pkg::spiph_idle && clock_phase_select_q && (sck_s ^ sck_d) && lead) begin
        start = 1'b1;
      end
      edge_ev = (sck_s ^ sck_d) && (st_q == spiph_pkg::spiph_run || start);
    end
    sample = lead ^ clock_phase_select_q;
    // Load: a late slave write resends the old shift contents
    if (start) begin
      if (!txe_q) begin
        src      = txbuf_q;
        next_txe = 1'b1;
      end
      next_dout  = src[7];
      next_tx_sh = {src[6:0], 1'b0};
      // Phase 1 start is itself the first edge, so count it
      next_ecnt  = {3'h0, edge_ev};
      next_drop  = 1'b0;
      next_st    = spiph_pkg::spiph_run;
    end
    if (edge_ev) begin
      if (m_act) begin
        next_sck = ~sck_q;
      end
      if (sample) begin
        next_rx_sh = {rx_sh_q[6:0], m_act ? miso_s : mosi_s};
        // first capture with unread byte: flag, drop the new byte
        if (ecnt_q == {3'h0, clock_phase_select_q} && rxf_q) begin
          next_ovr  = 1'b1;
          next_drop = 1'b1;
        end
      end else if (!start) begin
        next_dout  = tx_sh_q[7];
        next_tx_sh = {tx_sh_q[6:0], 1'b0};
      end
      if (!start) begin
        next_ecnt = 4'(ecnt_q + 4'h1);
      end
      // sixteenth edge ends the byte and fills the receiver
      if (ecnt_q == `SPIPH_LAST_EDGE && !start) begin
        next_st = spiph_pkg::spiph_idle;
        if (!next_drop) begin
          next_rxdata = next_rx_sh;
          next_rxf    = 1'b1;
        end
      end
    end
    // fault flag sets only with its enable
    // slave fault touches neither enable nor slave logic
    if (fault_s) begin
      next_mode_fault_flag = 1'b1;
    end
    // master fault disables, empties and clears the counter
    // master select bit is left as it was
    if (fault_m) begin
      next_mode_fault_flag = 1'b1;
      next_en   = 1'b0;
      next_txe  = 1'b1;
      next_st   = spiph_pkg::spiph_idle;
      next_ecnt = 4'h0;
    end
    // disabled block aborts and clears, sets transmit empty, other flags and control kept
    if (!en_q) begin
      next_txe   = 1'b1;
      next_st    = spiph_pkg::spiph_idle;
      next_ecnt  = 4'h0;
      next_tx_sh = `SPIPH_BYTE_RST;
      next_rx_sh = `SPIPH_BYTE_RST;
      next_sck   = clock_polarity_select_q;
    end
    // pins return to port control when disabled
    // master ignores its select only via the fault enable
    next_sck_oe  = m_act & ~fault_m;
    next_mosi_oe = m_act & ~fault_m;
    next_miso_oe = s_act & ~ss_s;
    // one error enable gates both error flags
    // receive and error share one request line
    next_irq_re = (rxie_q & en_q & rxf_q) | (erie_q & (ovr_q | mode_fault_flag_q));
    next_irq_tx = txie_q & txe_q;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {en_q, mst_q, clock_polarity_select_q, clock_phase_select_q} <= {4{`SPIPH_BIT_RST}};
      {rxie_q, txie_q, erie_q, mode_fault_enable_q} <= {4{`SPIPH_BIT_RST}};
      rate_q <= `SPIPH_RATE_RST;
      {rxf_q, ovr_q, mode_fault_flag_q} <= {3{`SPIPH_BIT_RST}};
      {rxf_arm_q, ovr_arm_q, mode_fault_flag_arm_q} <= {3{`SPIPH_BIT_RST}};
      txe_q <= `SPIPH_TXE_RST;
      {txbuf_q, rxdata_q, tx_sh_q, rx_sh_q} <= {4{`SPIPH_BYTE_RST}};
      st_q <= spiph_pkg::spiph_idle;
      ecnt_q <= 4'h0;
      div_q <= 7'h00;
      {dout_q, drop_q, sck_q, sck_oe_q} <= {4{`SPIPH_BIT_RST}};
      {mosi_oe_q, miso_oe_q, irq_re_q, irq_tx_q} <= {4{`SPIPH_BIT_RST}};
    end else begin
      {en_q, mst_q, clock_polarity_select_q, clock_phase_select_q} <= {next_en, next_mst, next_clock_polarity_select, next_clock_phase_select};
      {rxie_q, txie_q, erie_q, mode_fault_enable_q} <= {next_rxie, next_txie, next_erie, next_mode_fault_enable};
      rate_q <= next_rate;
      {rxf_q, ovr_q, mode_fault_flag_q} <= {next_rxf, next_ovr, next_mode_fault_flag};
      {rxf_arm_q, ovr_arm_q, mode_fault_flag_arm_q} <= {next_rxf_arm, next_ovr_arm, next_mode_fault_flag_arm};
      txe_q <= next_txe;
      {txbuf_q, rxdata_q, tx_sh_q, rx_sh_q} <= {next_txbuf, next_rxdata, next_tx_sh, next_rx_sh};
      st_q <= next_st;
      ecnt_q <= next_ecnt;
      div_q <= next_div;
      {dout_q, drop_q, sck_q, sck_oe_q} <= {next_dout, next_drop, next_sck, next_sck_oe};
      {mosi_oe_q, miso_oe_q, irq_re_q, irq_tx_q} <= {next_mosi_oe, next_miso_oe, next_irq_re, next_irq_tx};
    end
  end

  // Pin drivers; one data flop serves both roles
  assign sck_o        = sck_q;
  assign sck_oe_o     = sck_oe_q;
  assign mosi_o       = dout_q;
  assign mosi_oe_o    = mosi_oe_q;
  assign miso_o       = dout_q;
  assign miso_oe_o    = miso_oe_q;
  assign irq_rx_err_o = irq_re_q;
  assign irq_tx_o     = irq_tx_q;

  // ==========================================================
  // Assertions
  property p_miso_float;
    @(posedge clk_sys_i) disable iff (!nrst_i) ss_s |=> !miso_oe_o;
  endproperty
  a_miso_float: assert property (p_miso_float) else $error("slave output driven while deselected");

  property p_fault_gate;
    @(posedge clk_sys_i) disable iff (!nrst_i) (!mode_fault_enable_q && !mode_fault_flag_q) |=> !mode_fault_flag_q;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("fault flag set without enable");

  property p_master_fault;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (en_q && mst_q && mode_fault_enable_q && !ss_s) |=> (mode_fault_flag_q && !en_q && txe_q && st_q == spiph_pkg::spiph_idle)
      ##1 (!sck_oe_o && !mosi_oe_o);
  endproperty
  a_master_fault: assert property (p_master_fault) else $error("master fault effects missing");

  property p_mst_kept;
    @(posedge clk_sys_i) disable iff (!nrst_i) ($rose(mode_fault_flag_q) && !$past(wr_ctl)) |-> $stable(mst_q);
  endproperty
  a_mst_kept: assert property (p_mst_kept) else $error("fault changed master select");

  property p_start_delay;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr_data && en_q && mst_q && st_q == spiph_pkg::spiph_idle) |=> ##[0:128] (st_q == spiph_pkg::spiph_run || !en_q);
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("master transfer start too late");

  property p_overrun;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (edge_ev && sample && rxf_q && ecnt_q == {3'h0, clock_phase_select_q}) |=> (ovr_q && $stable(rxdata_q));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged or byte replaced");

  property p_disable;
    @(posedge clk_sys_i) disable iff (!nrst_i) !en_q |=> (txe_q && st_q == spiph_pkg::spiph_idle && ecnt_q == 4'h0);
  endproperty
  a_disable: assert property (p_disable) else $error("disabled block not partially reset");

  property p_mode_fault_flag_clear;
    @(posedge clk_sys_i) disable iff (!nrst_i) $fell(mode_fault_flag_q) |-> $past(wr_ctl && mode_fault_flag_arm_q);
  endproperty
  a_mode_fault_flag_clear: assert property (p_mode_fault_flag_clear) else $error("fault flag cleared out of sequence");

  property p_rxf_clear;
    @(posedge clk_sys_i) disable iff (!nrst_i) $fell(rxf_q) |-> $past(rd_data && rxf_arm_q);
  endproperty
  a_rxf_clear: assert property (p_rxf_clear) else $error("receive full cleared out of sequence");

  property p_err_gate;
    @(posedge clk_sys_i) disable iff (!nrst_i) (!erie_q && !(rxie_q && en_q && rxf_q)) |=> !irq_rx_err_o;
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("error request without shared enable");

  property p_slave_fault_keeps;
    @(posedge clk_sys_i) disable iff (!nrst_i) (fault_s && !wr_ctl) |=> (en_q && mode_fault_flag_q);
  endproperty
  a_slave_fault_keeps: assert property (p_slave_fault_keeps) else $error("slave fault changed enable");

endmodule // spiph_core

// *** src/spiph_defines.svh ***
// Register indices, field positions, reset values and rate masks of the serial block
`ifndef SPIPH_DEFINES_SVH
`define SPIPH_DEFINES_SVH

// ==========================================================
// Register indices, byte address is four times the index
`define SPIPH_IDX_CTRL   6'h10
`define SPIPH_IDX_STAT   6'h11
`define SPIPH_IDX_DATA   6'h12

// ==========================================================
// Control register fields
`define SPIPH_CTRL_RXIE  7
`define SPIPH_CTRL_MST   5
`define SPIPH_CTRL_CLOCK_POLARITY_SELECT  4
`define SPIPH_CTRL_CLOCK_PHASE_SELECT  3
`define SPIPH_CTRL_EN    1
`define SPIPH_CTRL_TXIE  0

// ==========================================================
// Status and control register fields
`define SPIPH_STAT_RXF    7
`define SPIPH_STAT_ERIE   6
`define SPIPH_STAT_OVR    5
`define SPIPH_STAT_MODE_FAULT_FLAG   4
`define SPIPH_STAT_TXE    3
`define SPIPH_STAT_MODE_FAULT_ENABLE 2
`define SPIPH_STAT_RATE   1:0

// ==========================================================
// Reset values
`define SPIPH_BIT_RST    1'b0
`define SPIPH_TXE_RST    1'b1
`define SPIPH_BYTE_RST   8'h00
`define SPIPH_RATE_RST   2'h0

// ==========================================================
// Divider masks: half bit and whole bit per rate setting
`define SPIPH_HALF_RATE_DIVIDE_TWO   7'h00
`define SPIPH_HALF_RATE_DIVIDE_EIGHT   7'h03
`define SPIPH_HALF_RATE_DIVIDE_THIRTYTWO  7'h0F
`define SPIPH_HALF_RATE_DIVIDE_ONETWENTYEIGHT 7'h3F
`define SPIPH_FULL_RATE_DIVIDE_TWO   7'h01
`define SPIPH_FULL_RATE_DIVIDE_EIGHT   7'h07
`define SPIPH_FULL_RATE_DIVIDE_THIRTYTWO  7'h1F
`define SPIPH_FULL_RATE_DIVIDE_ONETWENTYEIGHT 7'h7F
`define SPIPH_LAST_EDGE   4'hF

`endif

// *** src/spiph_pkg.sv ***
// Types shared by the serial block
package spiph_pkg;
  typedef enum logic {spiph_idle, spiph_run} spiph_state_e;
  typedef logic [7:0] spiph_byte_t;
endpackage

// *** testbench/spiph_peer.sv ***
// Behavioural far-side serial device, slave or master
`timescale 1ns/1ps
module spiph_peer (
  // Role and format
  input  wire logic       master_i,
  input  wire logic       clock_phase_select_i,
  // Wire levels seen
  input  wire logic       sck_i,
  input  wire logic       sdi_i,
  // Driven levels
  output logic            sck_o,
  output logic            sdo_o,
  output logic            ss_n_o,
  output logic [7:0]      rx_o
);
  logic [7:0] sh;
  // Idle: clock low, not selected
  initial begin
    sck_o = 1'b0;
    sdo_o = 1'b0;
    ss_n_o = 1'b1;
    rx_o = 8'h00;
    sh = 8'h00;
  end
  // phase 0 shows top bit early
  task automatic load(input logic [7:0] b);
    sh = b;
    sdo_o = b[7];
  endtask
  // sample leading in phase 0, trailing in phase 1
  always @(sck_i) begin
    if ((sck_i ^ clock_phase_select_i) === 1'b1) begin
      rx_o = {rx_o[6:0], sdi_i};
    end else if (clock_phase_select_i) begin
      sdo_o = sh[7];
      sh = {sh[6:0], 1'b0};
    end else begin
      sh = {sh[6:0], 1'b0};
      sdo_o = sh[7];
    end
  end
  // framed byte, clock stands still outside it
  task automatic xfer(input logic [7:0] b);
    load(b);
    #13 ss_n_o = 1'b0;
    repeat (16) begin
      #80 sck_o = ~sck_o;
    end
    #80 ss_n_o = 1'b1;
  endtask
endmodule // spiph_peer

// *** testbench/tb_spiph_core.sv ***
// Self-checking bench of the serial block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_spiph_core;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic avs_waitrequest_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic irq_rx_err_o, irq_tx_o, p_sck, p_sdo, p_ss_n, p_master = 1'b0, p_clock_phase_select = 1'b0;
  // own select held high in master role
  logic ss_n_r = 1'b1;
  logic [7:0] p_rx, q;
  int err_total = 0, total_checks = 0;
  // Wire levels; a released line shows the peer level, or its inverse on a data line the peer does not drive
  wire sck_w = sck_oe_o ? sck_o : p_sck;
  wire mosi_w = mosi_oe_o ? mosi_o : (p_master ? p_sdo : ~p_sdo);
  wire miso_w = miso_oe_o ? miso_o : (p_master ? ~p_sdo : p_sdo);
  logic [24:0] rows [0:7] = '{{1'b0, 8'h40, 8'h00, 8'h00}, {1'b0, 8'h44, 8'h00, 8'h08},
    {1'b0, 8'h4C, 8'h00, 8'h00}, {1'b1, 8'h44, 8'h47, 8'h00}, {1'b0, 8'h44, 8'h00, 8'h4F},
    {1'b1, 8'h4C, 8'hFF, 8'h00}, {1'b0, 8'h4C, 8'h00, 8'h00}, {1'b0, 8'h48, 8'h00, 8'h00}};
  spiph_core i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .ss_n_i(ss_n_r & p_ss_n), .irq_rx_err_o(irq_rx_err_o), .irq_tx_o(irq_tx_o));
  spiph_peer i_peer (.master_i(p_master), .clock_phase_select_i(p_clock_phase_select), .sck_i(sck_w),
    .sdi_i(p_master ? miso_w : mosi_w), .sck_o(p_sck), .sdo_o(p_sdo), .ss_n_o(p_ss_n), .rx_o(p_rx));
  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  // ==========================================================
  // Bus and helper tasks
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= {24'h0, d};
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wait_rx();
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 200 && s[7] !== 1'b1; n++) bus(1'b0, 8'h44, 8'h00, s);
    `CHK("rx full", 1'b1, s[7]);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog far beyond the expected run
  initial begin
    #300000;
    err_total++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(rows[i][24], rows[i][23:16], rows[i][15:8], q);
      if (!rows[i][24]) `CHK("reg", rows[i][7:0], q);
    end
    $display("register table done");
    // Master transfers in both phases at divide-by-eight rate
    for (int c = 0; c < 2; c++) begin
      p_clock_phase_select <= c[0];
      bus(1'b1, 8'h44, 8'h41, q);
      bus(1'b1, 8'h40, {4'h2, c[0], 3'h2}, q);
      i_peer.load(8'hA5);
      bus(1'b1, 8'h48, 8'h3C, q);
      wait_rx();
      bus(1'b0, 8'h48, 8'h00, q);
      `CHK("rx byte", 8'hA5, q);
      `CHK("peer byte", 8'h3C, p_rx);
      bus(1'b0, 8'h44, 8'h00, q);
      `CHK("stat", 8'h49, q);
      $display("master phase %0d done", c);
    end
    // Overrun keeps the unread byte
    i_peer.load(8'h11);
    bus(1'b1, 8'h48, 8'h01, q);
    wait_rx();
    i_peer.load(8'h22);
    bus(1'b1, 8'h48, 8'h02, q);
    repeat (60) @(posedge clk_sys_i);
    bus(1'b0, 8'h44, 8'h00, q);
    `CHK("ovr stat", 8'hE9, q);
    `CHK("err irq", 1'b1, irq_rx_err_o);
    bus(1'b0, 8'h48, 8'h00, q);
    `CHK("old byte", 8'h11, q);
    bus(1'b0, 8'h44, 8'h00, q);
    `CHK("ovr clear", 8'h49, q);
    $display("overrun done");
    // Master fault, gated by its enable
    ss_n_r <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    bus(1'b0, 8'h44, 8'h00, q);
    `CHK("no fault", 8'h49, q);
    bus(1'b1, 8'h44, 8'h44, q);
    repeat (8) @(posedge clk_sys_i);
    bus(1'b0, 8'h44, 8'h00, q);
    `CHK("fault", 8'h5C, q);
    `CHK("err irq", 1'b1, irq_rx_err_o);
    `CHK("sck oe", 1'b0, sck_oe_o);
    bus(1'b0, 8'h40, 8'h00, q);
    `CHK("ctrl", 8'h28, q);
    ss_n_r <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    bus(1'b0, 8'h44, 8'h00, q);
    bus(1'b1, 8'h40, 8'h00, q);
    bus(1'b0, 8'h44, 8'h00, q);
    `CHK("fault clear", 8'h4C, q);
    $display("master fault done");
    // Slave in phase 1: select pulse, then one byte
    p_master <= 1'b1;
    bus(1'b1, 8'h40, 8'h0A, q);
    ss_n_r <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    `CHK("miso oe", 1'b1, miso_oe_o);
    ss_n_r <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    `CHK("miso oe", 1'b0, miso_oe_o);
    bus(1'b0, 8'h44, 8'h00, q);
    `CHK("ph1 pulse", 8'h4C, q);
    bus(1'b1, 8'h48, 8'h5A, q);
    i_peer.xfer(8'hC3);
    `CHK("peer byte", 8'h5A, p_rx);
    wait_rx();
    bus(1'b0, 8'h48, 8'h00, q);
    `CHK("slave byte", 8'hC3, q);
    // Slave in phase 0: select pulse faults, enable stays
    bus(1'b1, 8'h40, 8'h00, q);
    bus(1'b1, 8'h40, 8'h03, q);
    ss_n_r <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    ss_n_r <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    bus(1'b0, 8'h44, 8'h00, q);
    `CHK("ph0 pulse", 8'h5C, q);
    bus(1'b0, 8'h40, 8'h00, q);
    `CHK("en kept", 8'h03, q);
    `CHK("tx irq", 1'b1, irq_tx_o);
    $display("slave done");
    summarize();
  end
endmodule // tb_spiph_core
